/* File: codec_power_ctrl.sv */
`timescale 1ns/100ps
`include "codec_cfg.svh"
module codec_power_ctrl #(
    parameter int SETTLE = `SETTLE_CYC,
    parameter logic [15:0] VID1 = `VID1_VAL,
    parameter logic [15:0] VID2 = `VID2_VAL,
    parameter logic [15:0] CAPS = `CAPS_VAL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link pins
    input wire logic reset_pin_n,
    input wire logic sync,
    input wire logic sdata_out,
    input wire logic bit_clk_src,
    output logic bit_clk_o,
    output logic bit_clk_oe,
    output logic sdata_in_o,
    output logic sdata_in_oe,
    // Analog section controls
    output codec_pkg::section_pd_type section_pd,
    output codec_pkg::route_type route,
    output logic [3:0] ready,
    // Test modes
    output logic ate_test_mode,
    output logic vendor_test_mode
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bit order: reset pin, sync, data out, bit clock
    logic [3:0] meta_q;
    logic [3:0] pin_q;
    logic [3:0] pin_d_q;
    logic cold;
    logic bclk_rise;
    logic bclk_fall;
    logic sync_rise;
    logic reset_release;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 4'h0;
            pin_q <= 4'h0;
            pin_d_q <= 4'h0;
        end else begin
            meta_q <= {reset_pin_n, sync, sdata_out, bit_clk_src};
            pin_q <= meta_q;
            pin_d_q <= pin_q;
        end
    end

    assign cold = !rst_n || !pin_q[3];
    assign bclk_rise = pin_q[0] && !pin_d_q[0];
    assign bclk_fall = !pin_q[0] && pin_d_q[0];
    assign sync_rise = pin_q[2] && !pin_d_q[2];
    assign reset_release = pin_q[3] && !pin_d_q[3];

    // ------------------------------------------------------------
    // Test mode entry
    // ------------------------------------------------------------
    // Only a cold reset leaves a test mode
    always_ff @(posedge clk) begin
        if (!rst_n || !pin_q[3]) begin
            ate_test_mode <= 1'b0;
            vendor_test_mode <= 1'b0;
        end else if (reset_release) begin
            ate_test_mode <= pin_q[1];
            vendor_test_mode <= pin_q[2] && !pin_q[1];
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    codec_pkg::link_cmd_type cmd;
    logic cmd_valid;
    logic wr;
    logic bypass_q;
    logic widen_q;
    logic mono_q;
    logic mic_q;
    logic loop_q;
    logic [1:0] depth_q;
    logic [6:0] pd_ctl_q;
    logic link_off;
    logic link_on;
    logic warm;
    logic line_down;

    assign wr = cmd_valid && !cmd.is_read;
    assign link_off = pd_ctl_q[`PD_LINK] || pd_ctl_q[`PD_CLK];
    assign link_on = !link_off && !ate_test_mode;
    // Sync pulse while the link sleeps is a warm reset
    assign warm = sync_rise && link_off;
    // One source for line power and its route, so both switch together
    assign line_down = pd_ctl_q[`PD_LINE] || pd_ctl_q[`PD_MIX]
        || pd_ctl_q[`PD_VREF];

    // Static storage: nothing but writes and resets touches these
    always_ff @(posedge clk) begin
        if (cold) begin
            bypass_q <= 1'b0;
            widen_q <= 1'b0;
            mono_q <= 1'b0;
            mic_q <= 1'b0;
            loop_q <= 1'b0;
            depth_q <= `DEPTH_RST;
        end else if (wr) begin
            case (cmd.index)
                `IDX_RESET: begin
                    bypass_q <= 1'b0;
                    widen_q <= 1'b0;
                    mono_q <= 1'b0;
                    mic_q <= 1'b0;
                    loop_q <= 1'b0;
                    depth_q <= `DEPTH_RST;
                end
                `IDX_MISC: begin
                    bypass_q <= cmd.data[`MISC_BYPASS_BIT];
                    widen_q <= cmd.data[`MISC_WIDEN_BIT];
                    mono_q <= cmd.data[`MISC_MONO_BIT];
                    mic_q <= cmd.data[`MISC_MIC_BIT];
                    loop_q <= cmd.data[`MISC_LOOP_BIT];
                end
                `IDX_DEPTH: begin
                    depth_q <= cmd.data[`DEPTH_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Power-down control; status bits are never stored here
    always_ff @(posedge clk) begin
        if (cold) begin
            pd_ctl_q <= `PD_CTL_RST;
        end else if (warm) begin
            pd_ctl_q[`PD_LINK] <= 1'b0;
            pd_ctl_q[`PD_CLK] <= 1'b0;
        end else if (wr && cmd.index == `IDX_PD) begin
            pd_ctl_q <= cmd.data[`PD_CTL_MSB:`PD_CTL_LSB];
        end
    end

    // ------------------------------------------------------------
    // Section power and routing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (cold) begin
            section_pd <= '0;
        end else begin
            section_pd.adc <= pd_ctl_q[`PD_ADC] || pd_ctl_q[`PD_VREF]
                || link_off;
            section_pd.dac <= pd_ctl_q[`PD_DAC] || pd_ctl_q[`PD_VREF]
                || link_off;
            section_pd.mixer <= pd_ctl_q[`PD_MIX]
                || pd_ctl_q[`PD_VREF];
            section_pd.vref <= pd_ctl_q[`PD_VREF];
            section_pd.link <= link_off;
            section_pd.clk <= pd_ctl_q[`PD_CLK];
            section_pd.true_line <= line_down;
        end
    end

    always_ff @(posedge clk) begin
        if (cold) begin
            route <= '0;
        end else begin
            route.pcm_via_widen <= !bypass_q;
            route.stereo_widen_on <= widen_q;
            route.widen_depth_hi <= depth_q[1];
            route.widen_depth_lo <= depth_q[0];
            route.mono_from_mic <= mono_q;
            route.mic_input_sel <= mic_q;
            route.converter_loopback <= loop_q;
            route.true_line_dac <= !bypass_q && !line_down;
        end
    end

    // ------------------------------------------------------------
    // Ready flags: reference, mixer, playback, record
    // ------------------------------------------------------------
    logic [3:0] sect_down;

    assign sect_down = {section_pd.vref, section_pd.mixer,
        section_pd.dac, section_pd.adc};

    // Cold reset clears every flag; a restored section must settle
    for (genvar i = 0; i < 4; i++) begin : g_settle
        section_settle #(
            .CYC(SETTLE),
            .CW(16)
        ) u_settle (
            .clk(clk),
            .rst_n(!cold),
            .pd(sect_down[i]),
            .ready(ready[i])
        );
    end

    // ------------------------------------------------------------
    // Command receive
    // ------------------------------------------------------------
    link_frame_rx u_rx (
        .clk(clk),
        .rst_n(!cold),
        .enable(link_on),
        .bclk_fall(bclk_fall),
        .sync_s(pin_q[2]),
        .sdo_s(pin_q[1]),
        .cmd(cmd),
        .cmd_valid(cmd_valid)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] rd_data;

    // Unmapped and unused bits read as zero
    always_comb begin
        rd_data = 16'h0000;
        case (cmd.index)
            `IDX_RESET: rd_data = CAPS;
            `IDX_MISC: begin
                rd_data[`MISC_BYPASS_BIT] = bypass_q;
                rd_data[`MISC_WIDEN_BIT] = widen_q;
                rd_data[`MISC_MONO_BIT] = mono_q;
                rd_data[`MISC_MIC_BIT] = mic_q;
                rd_data[`MISC_LOOP_BIT] = loop_q;
            end
            `IDX_DEPTH: rd_data[`DEPTH_MSB:0] = depth_q;
            `IDX_PD: begin
                rd_data[`PD_CTL_MSB:`PD_CTL_LSB] = pd_ctl_q;
                rd_data[3:0] = ready;
            end
            `IDX_VID1: rd_data = VID1;
            `IDX_VID2: rd_data = VID2;
            default: rd_data = 16'h0000;
        endcase
    end

    logic resp_pend_q;
    logic [6:0] resp_idx_q;
    logic [15:0] resp_data_q;
    logic tx_load;

    // Answer goes out in the next frame, once only
    always_ff @(posedge clk) begin
        if (cold || !link_on) begin
            resp_pend_q <= 1'b0;
            resp_idx_q <= 7'h00;
            resp_data_q <= 16'h0000;
        end else if (cmd_valid && cmd.is_read) begin
            resp_pend_q <= 1'b1;
            resp_idx_q <= cmd.index;
            resp_data_q <= rd_data;
        end else if (tx_load) begin
            resp_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status frame transmit
    // ------------------------------------------------------------
    logic sync_at_rise_q;
    logic [55:0] tx_q;

    assign tx_load = bclk_rise && pin_q[2] && !sync_at_rise_q;

    always_ff @(posedge clk) begin
        if (cold || !link_on) begin
            sync_at_rise_q <= 1'b0;
            tx_q <= 56'h0000_0000_0000_00;
        end else if (bclk_rise) begin
            sync_at_rise_q <= pin_q[2];
            if (tx_load) begin
                // Record tags stay invalid until the section is up
                tx_q <= {1'b1, resp_pend_q, resp_pend_q, ready[0],
                    ready[0], 11'h000, 1'b0, resp_idx_q, 12'h000,
                    resp_data_q, 4'h0};
            end else begin
                tx_q <= {tx_q[54:0], 1'b0};
            end
        end
    end

    assign sdata_in_o = tx_q[55];

    // Bit clock stops with the link; floats in board test
    always_ff @(posedge clk) begin
        if (cold) begin
            bit_clk_o <= 1'b0;
        end else begin
            bit_clk_o <= pin_q[0] && link_on;
        end
    end

    assign bit_clk_oe = !ate_test_mode;
    assign sdata_in_oe = !ate_test_mode;
endmodule

/* File: codec_cfg.svh */
// Operation
// - Bypass bit routes playback around widening
// - Widen enable bit switches enhancement on/off
// - Mono source bit picks mixer or mic
// - Mic select bit picks first or second
// - Loopback bit loops record data to playback
// - Bypass set removes playback from true line
// - Depth field selects 0/50/70/100 percent
// - Four read-only ready flags, 1 when ready
// - Writes alter the ready flags only through power-down bits
// - Seven power-down bits in upper byte
// - Power-down bits also stop dependent sections
// - Reference-off bit downs converters, mixer, line
// - Ready tags stay 0 until section up
// - Registers hold their values while clock stopped
// - Link power-down, warm reset clears and wakes
// - Clock stop, warm reset clears and wakes
// - Cold reset wakes and restores all defaults
// - Reset release samples data and sync pins
// - Board test floats link outputs; cold exits
// - Identity registers give three characters, revision
// - Reset register write spares power-down register
// - Ready flags read 0 after cold reset
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_RESET 7'h00
`define IDX_MISC 7'h20
`define IDX_DEPTH 7'h22
`define IDX_PD 7'h26
`define IDX_VID1 7'h7C
`define IDX_VID2 7'h7E
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MISC_BYPASS_BIT 15
`define MISC_WIDEN_BIT 13
`define MISC_MONO_BIT 9
`define MISC_MIC_BIT 8
`define MISC_LOOP_BIT 7
`define DEPTH_MSB 1
`define PD_CTL_MSB 14
`define PD_CTL_LSB 8
`define PD_ADC 0
`define PD_DAC 1
`define PD_MIX 2
`define PD_VREF 3
`define PD_LINK 4
`define PD_CLK 5
`define PD_LINE 6
// ----------------------------------------------------------------
// Reset values and arbitrary identity values
// ----------------------------------------------------------------
`define DEPTH_RST 2'h0
`define PD_CTL_RST 7'h00
`define VID1_VAL 16'h5859
`define VID2_VAL 16'h5A00
`define CAPS_VAL 16'h0000
// ----------------------------------------------------------------
// Frame layout and timing
// ----------------------------------------------------------------
`define RX_LAST 6'h37
`define SETTLE_CYC 64
`endif

/* File: codec_pkg.sv */
package codec_pkg;
    typedef struct packed {
        logic is_read;
        logic [6:0] index;
        logic [15:0] data;
    } link_cmd_type;
    typedef struct packed {
        logic adc;
        logic dac;
        logic mixer;
        logic vref;
        logic link;
        logic clk;
        logic true_line;
    } section_pd_type;
    typedef struct packed {
        logic pcm_via_widen;
        logic stereo_widen_on;
        logic widen_depth_hi;
        logic widen_depth_lo;
        logic mono_from_mic;
        logic mic_input_sel;
        logic converter_loopback;
        logic true_line_dac;
    } route_type;
endpackage

/* File: link_frame_rx.sv */
`timescale 1ns/100ps
`include "codec_cfg.svh"
module link_frame_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sampled link
    input wire logic enable,
    input wire logic bclk_fall,
    input wire logic sync_s,
    input wire logic sdo_s,
    // Decoded command
    output codec_pkg::link_cmd_type cmd,
    output logic cmd_valid
);
    logic sync_seen_q;
    logic busy_q;
    logic [5:0] cnt_q;
    logic [55:0] sh_q;
    logic [55:0] sh_d;

    assign sh_d = {sh_q[54:0], sdo_s};

    // ------------------------------------------------------------
    // Frame shift
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            sync_seen_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 6'h00;
            sh_q <= 56'h0000_0000_0000_00;
        end else if (bclk_fall) begin
            sync_seen_q <= sync_s;
            if (sync_s && !sync_seen_q) begin
                busy_q <= 1'b1;
                cnt_q <= 6'h01;
                sh_q <= {55'h0, sdo_s};
            end else if (busy_q) begin
                sh_q <= sh_d;
                cnt_q <= 6'(cnt_q + 6'h01);
                if (cnt_q == `RX_LAST) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Command decode at end of slot 2
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            cmd_valid <= 1'b0;
            cmd <= '0;
        end else begin
            cmd_valid <= bclk_fall && busy_q && cnt_q == `RX_LAST
                && sh_d[55] && sh_d[54] && (sh_d[39] || sh_d[53]);
            if (bclk_fall && busy_q && cnt_q == `RX_LAST) begin
                cmd.is_read <= sh_d[39];
                cmd.index <= sh_d[38:32];
                cmd.data <= sh_d[19:4];
            end
        end
    end
endmodule

/* File: section_settle.sv */
`timescale 1ns/100ps
module section_settle #(
    parameter int CYC = 64,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Section control
    input wire logic pd,
    output logic ready
);
    logic [CW-1:0] cnt_q;

    // Powered sections count up before reporting ready
    always_ff @(posedge clk) begin
        if (!rst_n || pd) begin
            cnt_q <= '0;
            ready <= 1'b0;
        end else if (cnt_q == CW'(CYC)) begin
            ready <= 1'b1;
        end else begin
            cnt_q <= CW'(cnt_q + 1'b1);
        end
    end
endmodule

/* File: codec_power_ctrl_asserts.sv */
`timescale 1ns/100ps
module codec_power_ctrl_asserts #(
    parameter int SETTLE = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link pins
    input wire logic reset_pin_n,
    input wire logic sync,
    input wire logic sdata_out,
    input wire logic bit_clk_oe,
    input wire logic sdata_in_oe,
    // Section state
    input codec_pkg::section_pd_type section_pd,
    input codec_pkg::route_type route,
    input wire logic [3:0] ready,
    input wire logic ate_test_mode,
    input wire logic vendor_test_mode
);
    logic [3:0] pd_vec;
    logic [15:0] low_cnt_q [4];
    assign pd_vec = {section_pd.vref, section_pd.mixer, section_pd.dac,
        section_pd.adc};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Settle counters, saturating so a long idle never wraps
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n || pd_vec[i]) begin
                low_cnt_q[i] <= 16'h0000;
            end else if (low_cnt_q[i] != 16'hFFFF) begin
                low_cnt_q[i] <= low_cnt_q[i] + 16'h0001;
            end
        end
    end
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Pins are synchronised, so quiet means quiet for three samples
    sequence pins_quiet;
        !sync && !$past(sync) && !$past(sync, 2) && reset_pin_n
            && $past(reset_pin_n) && $past(reset_pin_n, 2);
    endsequence
    sequence link_awake;
        !section_pd.link && !section_pd.clk;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ready_drop_a: assert property (
        (|pd_vec) |=> (ready & $past(pd_vec)) == 4'h0)
        else $error("ready flag high for a section that is down");
    for (genvar i = 0; i < 4; i++) begin : g_settle
        ready_settle_a: assert property (
            @(posedge clk) disable iff (!rst_n)
            $rose(ready[i]) |-> low_cnt_q[i] >= 16'(SETTLE))
            else $error("ready flag rose before its section settled");
    end
    vref_group_a: assert property (
        section_pd.vref |-> section_pd.adc && section_pd.dac
            && section_pd.mixer && section_pd.true_line)
        else $error("reference down without its dependent sections");
    pd_cascade_a: assert property (
        (!section_pd.link || section_pd.adc && section_pd.dac)
        && (!section_pd.clk || section_pd.link)
        && (!section_pd.mixer || section_pd.true_line))
        else $error("power-down cascade broken");
    line_dac_a: assert property (
        route.true_line_dac |-> route.pcm_via_widen
            && !section_pd.true_line)
        else $error("playback on true line while bypassed or down");
    ate_float_a: assert property (
        ate_test_mode |-> !bit_clk_oe && !sdata_in_oe)
        else $error("link outputs driven in board test mode");
    ate_entry_a: assert property (
        $rose(ate_test_mode) |-> reset_pin_n && $past(sdata_out, 3))
        else $error("board test mode entered without data pin high");
    vendor_entry_a: assert property (
        $rose(vendor_test_mode) |-> $past(sync, 3)
            && !$past(sdata_out, 3))
        else $error("vendor test mode entered on wrong pin levels");
    test_exit_a: assert property (
        (ate_test_mode || vendor_test_mode) ##0 pins_quiet
        |=> $stable({ate_test_mode, vendor_test_mode}))
        else $error("test mode left without cold reset");
    sleep_hold_a: assert property (
        section_pd.link ##0 pins_quiet
        |=> $stable(section_pd) && $stable(route))
        else $error("state changed while link asleep");
    warm_wake_a: assert property (
        section_pd.link && reset_pin_n && $rose(sync)
        |-> ##[1:10] link_awake)
        else $error("warm reset did not wake link");
    cold_default_a: assert property (
        !reset_pin_n [*4] |=> section_pd == '0 && ready == 4'h0
            && !ate_test_mode && !vendor_test_mode)
        else $error("cold reset left state set");
endmodule

bind codec_power_ctrl codec_power_ctrl_asserts #(.SETTLE(SETTLE)) chk (
    .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sync(sync),
    .sdata_out(sdata_out), .bit_clk_oe(bit_clk_oe),
    .sdata_in_oe(sdata_in_oe), .section_pd(section_pd), .route(route),
    .ready(ready), .ate_test_mode(ate_test_mode),
    .vendor_test_mode(vendor_test_mode)
);

/* File: codec_link_host.sv */
`timescale 1ns/100ps
module codec_link_host (
    // Link from codec
    input wire logic bclk,
    input wire logic sdi,
    // Link to codec
    output logic reset_pin_n,
    output logic sync,
    output logic sdo
);
    logic [63:0] rx;
    initial begin
        reset_pin_n = 1'b0;
        sync = 1'b0;
        sdo = 1'b0;
    end
    // ------------------------------------------------------------
    // Frames, answer stream shifted in meanwhile
    // ------------------------------------------------------------
    task automatic frame(input logic rd, input logic [6:0] idx,
            input logic [15:0] data, input logic valid);
        logic [55:0] f;
        f = {valid, valid, valid & !rd, 13'h0000, rd, idx, 12'h000, data,
            4'h0};
        for (int i = 0; i < 64; i++) begin
            @(posedge bclk);
            sync <= (i < 16);
            sdo <= (i < 56) ? f[55 - i] : 1'b0;
            @(negedge bclk);
            rx = {rx[62:0], sdi};
        end
    endtask
    task automatic write_reg(input logic [6:0] idx, input logic [15:0] d);
        frame(1'b0, idx, d, 1'b1);
    endtask
    // Answer comes one frame late; its start is found by the ready bit
    task automatic read_reg(input logic [6:0] idx, output logic [15:0] d);
        logic [63:0] r;
        frame(1'b1, idx, 16'h0000, 1'b1);
        frame(1'b0, 7'h00, 16'h0000, 1'b0);
        r = rx;
        for (int i = 0; i < 16 && r[63] !== 1'b1; i++) begin
            r = r << 1;
        end
        d = (r[62:61] === 2'b11 && r[46:40] === idx) ? r[27:12] : 'x;
    endtask
    task automatic warm();
        @(posedge bclk);
        sync <= 1'b1;
        repeat (8) @(posedge bclk);
        sync <= 1'b0;
        repeat (8) @(posedge bclk);
    endtask
    // Test pin levels only when a test asks for them
    task automatic cold(input logic sdo_v, input logic sync_v);
        @(posedge bclk);
        reset_pin_n <= 1'b0;
        sync <= sync_v;
        sdo <= sdo_v;
        repeat (8) @(posedge bclk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge bclk);
        sync <= 1'b0;
        sdo <= 1'b0;
        repeat (8) @(posedge bclk);
    endtask
endmodule

/* File: codec_power_ctrl_tb.sv */
`timescale 1ns/100ps
module codec_power_ctrl_tb;
    localparam int SETTLE = 4;
    // Identity values are arbitrary
    localparam logic [15:0] VID_A = 16'h5859;
    localparam logic [15:0] VID_B = 16'h5A07;
    typedef struct packed {
        logic [6:0] idx;
        logic [15:0] wr;
        logic [15:0] rd;
        logic [7:0] rt;
        logic [6:0] pd;
    } row_type;
    row_type rows [18] = '{
        {7'h20, 16'hA380, 16'hA380, 8'h4E, 7'h00},
        {7'h20, 16'hFFFF, 16'hA380, 8'h4E, 7'h00},
        {7'h20, 16'h2000, 16'h2000, 8'hC1, 7'h00},
        {7'h22, 16'h0001, 16'h0001, 8'hD1, 7'h00},
        {7'h22, 16'h0002, 16'h0002, 8'hE1, 7'h00},
        {7'h22, 16'hFFFF, 16'h0003, 8'hF1, 7'h00},
        {7'h7C, 16'h1234, VID_A, 8'hF1, 7'h00},
        {7'h7E, 16'h0000, VID_B, 8'hF1, 7'h00},
        {7'h30, 16'h5555, 16'h0000, 8'hF1, 7'h00},
        {7'h00, 16'h0000, 16'h0000, 8'h81, 7'h00},
        {7'h26, 16'h0000, 16'h000F, 8'h81, 7'h00},
        {7'h26, 16'h0100, 16'h010E, 8'h81, 7'h40},
        {7'h26, 16'h0300, 16'h030C, 8'h81, 7'h60},
        {7'h26, 16'h0700, 16'h0708, 8'h80, 7'h71},
        {7'h26, 16'h0F00, 16'h0F00, 8'h80, 7'h79},
        {7'h00, 16'h0000, 16'h0000, 8'h80, 7'h79},
        {7'h26, 16'h4F00, 16'h4F00, 8'h80, 7'h79},
        {7'h26, 16'h4700, 16'h4708, 8'h80, 7'h71}};
    logic clk = 1'b0;
    logic rst_n;
    logic bclk;
    logic reset_pin_n, sync, sdo, sdi;
    logic bit_clk_o, bit_clk_oe, sdata_in_o, sdata_in_oe, ate, vendor;
    codec_pkg::section_pd_type section_pd;
    codec_pkg::route_type route;
    logic [3:0] ready;
    logic [15:0] rdat;
    int n_errors, check_count;
    // Floating pin when the codec lets go
    assign sdi = sdata_in_oe ? sdata_in_o : 1'bz;
    always #5 clk = ~clk;
    // Offset keeps link edges away from system clock edges
    initial begin
        bclk = 1'b0;
        #2;
        forever #62.5 bclk = ~bclk;
    end
    codec_power_ctrl #(.SETTLE(SETTLE), .VID1(VID_A), .VID2(VID_B),
        .CAPS(16'h0000)) dut (
        .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .sync(sync),
        .sdata_out(sdo), .bit_clk_src(bclk), .bit_clk_o(bit_clk_o),
        .bit_clk_oe(bit_clk_oe), .sdata_in_o(sdata_in_o),
        .sdata_in_oe(sdata_in_oe), .section_pd(section_pd), .route(route),
        .ready(ready), .ate_test_mode(ate), .vendor_test_mode(vendor));
    codec_link_host link (.bclk(bclk), .sdi(sdi),
        .reset_pin_n(reset_pin_n), .sync(sync), .sdo(sdo));
    // ------------------------------------------------------------
    // Compare and close
    // ------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_errors++;
        close_out();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        n_errors = 0;
        check_count = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk8({4'h0, ready}, 8'h00);
        link.cold(1'b0, 1'b0);
        for (int i = 0; i < 200 && ready !== 4'hF; i++) begin
            @(negedge clk);
        end
        chk8({4'h0, ready}, 8'h0F);
        for (int i = 0; i < 18; i++) begin
            link.write_reg(rows[i].idx, rows[i].wr);
            link.read_reg(rows[i].idx, rdat);
            chk16(rdat, rows[i].rd);
            chk8({7'h00, link.rx[60]}, {7'h00, !rows[i].pd[6]});
            chk8(route, rows[i].rt);
            chk8({1'b0, section_pd}, {1'b0, rows[i].pd});
        end
        // Link goes last, after converters, mixer and line are off; reference stays on
        link.write_reg(7'h26, 16'h5700);
        chk8({1'b0, section_pd}, 8'h75);
        chk8({7'h00, bit_clk_o}, 8'h00);
        link.warm();
        chk8({1'b0, section_pd}, 8'h71);
        chk8(route, 8'h80);
        link.read_reg(7'h26, rdat);
        chk16(rdat, 16'h4708);
        link.write_reg(7'h26, 16'h6700);
        chk8({1'b0, section_pd}, 8'h77);
        chk8({7'h00, bit_clk_o}, 8'h00);
        link.warm();
        chk8({1'b0, section_pd}, 8'h71);
        link.write_reg(7'h20, 16'hA380);
        link.write_reg(7'h22, 16'h0003);
        chk8(route, 8'h7E);
        link.cold(1'b0, 1'b0);
        chk8({1'b0, section_pd}, 8'h00);
        chk8(route, 8'h81);
        link.cold(1'b1, 1'b0);
        chk8({4'h0, ate, vendor, bit_clk_oe, sdata_in_oe}, 8'h08);
        link.cold(1'b0, 1'b1);
        chk8({4'h0, ate, vendor, bit_clk_oe, sdata_in_oe}, 8'h07);
        link.cold(1'b0, 1'b0);
        chk8({4'h0, ate, vendor, bit_clk_oe, sdata_in_oe}, 8'h03);
        close_out();
    end
endmodule
